// file: verilog/ssrcb_pkg.sv
`default_nettype none

package ssrcb_pkg;

    // fifo geometry, shared by the inbound and outbound speed-matching fifos
    localparam int          FIFO_DEPTH = 16;
    localparam int          FIFO_AW    = 4;
    localparam logic [4:0]  FIFO_FULL  = 5'h10;    // count value of a full fifo
    localparam logic [3:0]  PTR_STEP   = 4'h1;
    localparam int          FIS_WORDS  = 5;        // words kept of a non-data frame
    localparam logic [2:0]  FIS_LAST   = 3'h4;     // index of the last kept word

    // register byte addresses on the software port
    localparam logic [5:0]  ADDR_DATA   = 6'h00;   // shadow data register
    localparam logic [5:0]  ADDR_ERRFT  = 6'h04;   // read error, write features
    localparam logic [5:0]  ADDR_SECT   = 6'h08;   // sector count / tag
    localparam logic [5:0]  ADDR_LBA    = 6'h0c;   // 24-bit block address
    localparam logic [5:0]  ADDR_DEV    = 6'h10;   // device register
    localparam logic [5:0]  ADDR_STCMD  = 6'h14;   // read status, write command
    localparam logic [5:0]  ADDR_ALTCTL = 6'h18;   // read alt status, write device control
    localparam logic [5:0]  ADDR_ADPCTL = 6'h1c;   // adapter control
    localparam logic [5:0]  ADDR_ADPST  = 6'h20;   // adapter state, read only

    // adapter control fields
    localparam int          CTL_DMA_RUN  = 0;      // dma engine armed
    localparam int          CTL_DROP_CLR = 1;      // write one clears dropped-write flag

    // frame type codes
    localparam logic [7:0]  FIS_REG_H2D   = 8'h27;
    localparam logic [7:0]  FIS_REG_D2H   = 8'h34;
    localparam logic [7:0]  FIS_SDB       = 8'ha1;
    localparam logic [7:0]  FIS_PIO_SETUP = 8'h5f;
    localparam logic [7:0]  FIS_DATA      = 8'h46;

    // header word fields
    localparam int          HDR_DIR  = 13;         // pio setup: one = device to host
    localparam int          HDR_IRQ  = 14;         // interrupt flag
    localparam int          HDR_CMD  = 15;         // command bit of an outbound register frame

    // shadow status bit positions
    localparam int          ST_BUSY  = 7;
    localparam int          ST_SERVICE_REQUEST_FLAG  = 4;
    localparam int          ST_DRQ   = 3;
    localparam int          ST_REL   = 2;
    localparam int          ST_ERR   = 0;

    localparam logic [15:0] CNT_ONE  = 16'h0001;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_HDR  = 2'b01,
        RX_DATA = 2'b10
    } ssrcb_rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_CMD  = 2'b01,
        TX_DATA = 2'b10
    } ssrcb_tx_state_t;

    typedef logic [FIS_WORDS-1:0][31:0]  ssrcb_fis_t;
    typedef logic [FIFO_DEPTH-1:0][31:0] ssrcb_mem_t;

    // one word on the frame link
    typedef struct packed {
        logic        sof;       // first word of a frame
        logic        eof;       // last word of a frame
        logic [31:0] data;      // payload
    } ssrcb_word_t;

    // whole state of the bridge
    typedef struct packed {
        ssrcb_rx_state_t rx_st;
        ssrcb_tx_state_t tx_st;
        logic [7:0]      status;
        logic [7:0]      error;
        logic [7:0]      feature;
        logic [7:0]      command;
        logic [7:0]      sect;
        logic [7:0]      device;
        logic [7:0]      devctl;
        logic [23:0]     lba;
        logic            intrq;
        logic            cmd_pend;
        logic            dma_run;
        logic            tx_drop;
        logic            hold_valid;
        ssrcb_fis_t      hold_w;
        ssrcb_fis_t      rxw;
        logic [2:0]      rx_idx;
        logic [2:0]      tx_idx;
        logic            pio_in;
        logic            pio_out;
        logic [7:0]      end_status;
        logic [15:0]     rd_left;
        logic [15:0]     wr_left;
        logic [15:0]     tx_left;
        ssrcb_mem_t      rx_mem;
        logic [3:0]      rx_wp;
        logic [3:0]      rx_rp;
        logic [4:0]      rx_cnt;
        ssrcb_mem_t      tx_mem;
        logic [3:0]      tx_wp;
        logic [3:0]      tx_rp;
        logic [4:0]      tx_cnt;
        logic [31:0]     rdata;
        logic            rx_ready;
        logic            dma_valid;
        logic [31:0]     dma_data;
        logic            tx_valid;
        ssrcb_word_t     tx_word;
    } ssrcb_state_t;

endpackage

`default_nettype wire

// file: verilog/ssrcb_bridge.sv
`timescale 1ns/100ps
`default_nettype none

module ssrcb_bridge
    import ssrcb_pkg::*;
(
    input  wire logic        clk_i,        // 20 MHz clock
    input  wire logic        reset_i,      // async reset, active high
    input  wire logic [5:0]  addr_i,       // register byte address
    input  wire logic [31:0] wdata_i,      // register write data
    input  wire logic        wr_i,         // write strobe
    input  wire logic        rd_i,         // read strobe
    output logic      [31:0] rdata_o,      // read data, cycle after strobe
    output logic             intrq_o,      // interrupt to host
    input  wire logic        rx_valid_i,   // inbound link word valid
    input  wire ssrcb_word_t rx_word_i,    // inbound link word
    output logic             rx_ready_o,   // inbound flow control
    output logic             tx_valid_o,   // outbound link word valid
    output ssrcb_word_t      tx_word_o,    // outbound link word
    input  wire logic        tx_ready_i,   // outbound flow control
    output logic             dma_valid_o,  // word toward dma engine
    output logic      [31:0] dma_data_o,   // dma word
    input  wire logic        dma_ready_i   // dma engine takes word
);

    ssrcb_state_t r;    // registered state
    ssrcb_state_t n;    // next state

    // advance a fifo pointer with wrap
    function automatic logic [3:0] ptr_inc(input logic [3:0] p);
        return p + PTR_STEP;
    endfunction

    // copy register contents of a frame into the shadow blocks
    function automatic ssrcb_state_t load_shadow(input ssrcb_state_t s, input ssrcb_fis_t w);
        ssrcb_state_t o;
        o        = s;
        o.status = w[0][23:16];
        o.error  = w[0][31:24];
        o.lba    = w[1][23:0];
        o.device = w[1][31:24];
        o.sect   = w[3][7:0];
        return o;
    endfunction

    // words of the outbound register frame, built from the shadow blocks
    function automatic logic [31:0] cmd_word(input ssrcb_state_t s, input logic [2:0] idx);
        logic [31:0] v;
        v = '0;
        case (idx)
            3'h0: v = {s.feature, s.command, 1'b1, 7'h00, FIS_REG_H2D};
            3'h1: v = {s.device, s.lba};
            3'h3: v = {s.devctl, 16'h0000, s.sect};
            default: v = '0;
        endcase
        return v;
    endfunction

    // next-state logic of the whole bridge
    always_comb begin
        logic        rx_take;
        logic        rx_push;
        logic        rx_pop;
        logic        tx_push;
        logic        tx_pop;
        logic [31:0] rx_in;
        logic [31:0] tx_in;
        logic [7:0]  ftype;
        ssrcb_fis_t  w;
        n       = r;
        rx_take = rx_valid_i && r.rx_ready;
        rx_push = 1'b0;
        rx_pop  = 1'b0;
        tx_push = 1'b0;
        tx_pop  = 1'b0;
        rx_in   = rx_word_i.data;
        tx_in   = wdata_i;
        ftype   = rx_word_i.data[7:0];
        w       = r.rxw;
        n.rdata = '0;

        // outbound link: one word per accepted slot; a data frame leaves empty slots mid-frame while the fifo is empty
        if (!r.tx_valid || tx_ready_i) begin
            n.tx_valid = 1'b0;
            n.tx_word  = '0;
            case (r.tx_st)
                TX_IDLE: begin
                    if (r.cmd_pend) begin
                        // queued command frame goes first
                        n.tx_valid     = 1'b1;
                        n.tx_word.sof  = 1'b1;
                        n.tx_word.data = cmd_word(r, 3'h0);
                        n.tx_idx       = 3'h1;
                        n.cmd_pend     = 1'b0;
                        n.tx_st        = TX_CMD;
                    end else if (r.tx_left != 16'h0000 && r.tx_cnt != 5'h00) begin
                        // open a data frame only once a word waits
                        n.tx_valid     = 1'b1;
                        n.tx_word.sof  = 1'b1;
                        n.tx_word.data = {24'h000000, FIS_DATA};
                        n.tx_st        = TX_DATA;
                    end
                end
                TX_CMD: begin
                    // remaining words of the register frame
                    n.tx_valid     = 1'b1;
                    n.tx_word.data = cmd_word(r, r.tx_idx);
                    n.tx_word.eof  = (r.tx_idx == FIS_LAST);
                    n.tx_idx       = r.tx_idx + 3'h1;
                    if (r.tx_idx == FIS_LAST) begin
                        n.tx_st = TX_IDLE;
                    end
                end
                TX_DATA: begin
                    // hold off rather than underflow while the fifo is empty
                    if (r.tx_cnt != 5'h00) begin
                        n.tx_valid     = 1'b1;
                        n.tx_word.data = r.tx_mem[r.tx_rp];
                        n.tx_word.eof  = (r.tx_left == CNT_ONE);
                        tx_pop         = 1'b1;
                        n.tx_left      = r.tx_left - CNT_ONE;
                        if (r.tx_left == CNT_ONE) begin
                            n.tx_st = TX_IDLE;
                        end
                    end
                end
                default: n.tx_st = TX_IDLE;
            endcase
        end

        // software writes
        if (wr_i) begin
            case (addr_i)
                ADDR_DATA: begin
                    // out operation: only while a pio write is open
                    if (r.pio_out && r.wr_left != 16'h0000) begin
                        if (r.tx_cnt != FIFO_FULL) begin
                            tx_push   = 1'b1;
                            n.wr_left = r.wr_left - CNT_ONE;
                            if (r.wr_left == CNT_ONE) begin
                                n.status          = r.end_status;
                                n.status[ST_DRQ]  = 1'b0;
                                n.pio_out         = 1'b0;
                            end
                        end else begin
                            n.tx_drop = 1'b1;                             // full: write lost
                        end
                    end
                end
                ADDR_ERRFT:  n.feature = wdata_i[7:0];
                ADDR_SECT:   n.sect    = wdata_i[7:0];
                ADDR_LBA:    n.lba     = wdata_i[23:0];
                ADDR_DEV:    n.device  = wdata_i[7:0];
                ADDR_STCMD: begin
                    // command written last: busy and a frame to the device
                    n.command         = wdata_i[7:0];
                    n.status[ST_BUSY] = 1'b1;
                    n.status[ST_DRQ]  = 1'b0;
                    n.cmd_pend        = 1'b1;
                end
                ADDR_ALTCTL: n.devctl  = wdata_i[7:0];
                ADDR_ADPCTL: begin
                    n.dma_run = wdata_i[CTL_DMA_RUN];
                    if (wdata_i[CTL_DROP_CLR]) begin
                        n.tx_drop = 1'b0;
                    end
                end
                default: ;                                                // unmapped: ignored
            endcase
        end

        // software reads, answered in the next cycle
        if (rd_i) begin
            case (addr_i)
                ADDR_DATA: begin
                    // in operation: pop the inbound fifo head
                    if (r.pio_in && r.rx_cnt != 5'h00) begin
                        n.rdata   = r.rx_mem[r.rx_rp];
                        rx_pop    = 1'b1;
                        n.rd_left = r.rd_left - CNT_ONE;
                        if (r.rd_left == CNT_ONE) begin
                            n.status         = r.end_status;
                            n.status[ST_DRQ] = 1'b0;
                            n.pio_in         = 1'b0;
                        end
                    end
                end
                ADDR_ERRFT:  n.rdata = {24'h000000, r.error};
                ADDR_SECT:   n.rdata = {24'h000000, r.sect};
                ADDR_LBA:    n.rdata = {8'h00, r.lba};
                ADDR_DEV:    n.rdata = {24'h000000, r.device};
                ADDR_STCMD: begin
                    // status read acknowledges the interrupt
                    n.rdata = {24'h000000, r.status};
                    n.intrq = 1'b0;
                end
                ADDR_ALTCTL: n.rdata = {24'h000000, r.status};
                ADDR_ADPCTL: n.rdata = {31'h00000000, r.dma_run};
                ADDR_ADPST:  n.rdata = {16'h0000, r.tx_drop, r.hold_valid, r.pio_out,
                                        r.pio_in, r.tx_cnt, 2'h0, r.rx_cnt};
                default:     n.rdata = '0;
            endcase
        end

        // inbound link frames; events here come after the clears above
        if (rx_take) begin
            case (r.rx_st)
                RX_IDLE: begin
                    if (rx_word_i.sof) begin
                        n.rxw[0] = rx_in;
                        n.rx_idx = 3'h1;
                        if (ftype == FIS_DATA) begin
                            n.rx_st = rx_word_i.eof ? RX_IDLE : RX_DATA;
                            if (r.hold_valid) begin
                                // held setup now takes effect
                                n                 = load_shadow(n, r.hold_w);
                                n.status[ST_DRQ]  = 1'b1;
                                n.status[ST_BUSY] = 1'b0;
                                n.end_status      = r.hold_w[3][31:24];
                                n.rd_left         = r.hold_w[4][15:0];
                                n.pio_in          = (r.hold_w[4][15:0] != 16'h0000);
                                n.hold_valid      = 1'b0;
                                if (r.hold_w[0][HDR_IRQ]) begin
                                    n.intrq = 1'b1;
                                end
                            end
                        end else begin
                            n.rx_st = rx_word_i.eof ? RX_IDLE : RX_HDR;
                        end
                    end
                end
                RX_HDR: begin
                    if (r.rx_idx <= FIS_LAST) begin
                        n.rxw[r.rx_idx] = rx_in;
                        n.rx_idx        = r.rx_idx + 3'h1;
                    end
                    if (rx_word_i.eof) begin
                        n.rx_st = RX_IDLE;
                        w       = n.rxw;
                        case (w[0][7:0])
                            FIS_REG_D2H: begin
                                // release, tag answer and completion all land here
                                n = load_shadow(n, w);
                                n.rx_st = RX_IDLE;
                                if (w[0][HDR_IRQ]) begin
                                    n.intrq = 1'b1;
                                end
                            end
                            FIS_SDB: begin
                                n.status[ST_SERVICE_REQUEST_FLAG] = 1'b1;
                                if (!r.status[ST_BUSY]) begin
                                    n.intrq = 1'b1;
                                end
                            end
                            FIS_PIO_SETUP: begin
                                n.hold_w = w;
                                if (w[0][HDR_DIR]) begin
                                    n.hold_valid = 1'b1;
                                end else if (w[0][16+ST_ERR]) begin
                                    // error on a write: frame ends the command
                                    n = load_shadow(n, w);
                                    n.rx_st   = RX_IDLE;
                                    n.hold_w  = w;
                                    n.pio_out = 1'b0;
                                    n.wr_left = 16'h0000;
                                    n.intrq   = n.intrq | w[0][HDR_IRQ];
                                end else begin
                                    // write direction: beginning status at once
                                    n = load_shadow(n, w);
                                    n.rx_st           = RX_IDLE;
                                    n.hold_w          = w;
                                    n.status[ST_DRQ]  = 1'b1;
                                    n.status[ST_BUSY] = 1'b0;
                                    n.end_status      = w[3][31:24];
                                    n.wr_left         = w[4][15:0];
                                    n.tx_left         = w[4][15:0];
                                    n.pio_out         = (w[4][15:0] != 16'h0000);
                                    n.intrq           = n.intrq | w[0][HDR_IRQ];
                                end
                            end
                            default: ;                                    // unknown frame dropped
                        endcase
                    end
                end
                RX_DATA: begin
                    // payload always enters the inbound fifo
                    rx_push = 1'b1;
                    if (rx_word_i.eof) begin
                        n.rx_st = RX_IDLE;
                    end
                end
                default: n.rx_st = RX_IDLE;
            endcase
        end

        // drain to the dma engine when armed and no pio read owns the fifo
        if (!r.dma_valid || dma_ready_i) begin
            n.dma_valid = 1'b0;
            if (!r.pio_in && r.dma_run && r.rx_cnt != 5'h00) begin
                n.dma_valid = 1'b1;
                n.dma_data  = r.rx_mem[r.rx_rp];
                rx_pop      = 1'b1;
            end
        end

        // fifo bookkeeping
        if (rx_push) begin
            n.rx_mem[r.rx_wp] = rx_in;
            n.rx_wp           = ptr_inc(r.rx_wp);
        end
        if (rx_pop) begin
            n.rx_rp = ptr_inc(r.rx_rp);
        end
        n.rx_cnt = r.rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
        if (tx_push) begin
            n.tx_mem[r.tx_wp] = tx_in;
            n.tx_wp           = ptr_inc(r.tx_wp);
        end
        if (tx_pop) begin
            n.tx_rp = ptr_inc(r.tx_rp);
        end
        n.tx_cnt = r.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};

        // accept a link word only while a slot is sure to be free next cycle
        n.rx_ready = (n.rx_cnt < FIFO_FULL);
    end

    // state register; reset empties both fifos and drops any held setup
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state register
    assign rdata_o     = r.rdata;
    assign intrq_o     = r.intrq;
    assign rx_ready_o  = r.rx_ready;
    assign tx_valid_o  = r.tx_valid;
    assign tx_word_o   = r.tx_word;
    assign dma_valid_o = r.dma_valid;
    assign dma_data_o  = r.dma_data;

endmodule

`default_nettype wire

// file: verif/ssrcb_props.sv
`timescale 1ns/100ps
`default_nettype none
module ssrcb_props
    import ssrcb_pkg::*;
(
    input wire logic        clk_i,       // clock
    input wire logic        reset_i,     // reset
    input wire logic [5:0]  addr_i,      // address
    input wire logic        wr_i,        // write
    input wire logic        rd_i,        // read
    input wire logic [31:0] rdata_o,     // read data
    input wire logic        intrq_o,     // interrupt
    input wire logic        rx_valid_i,  // rx valid
    input wire logic        rx_ready_o,  // rx ready
    input wire logic        tx_valid_o,  // tx valid
    input wire ssrcb_word_t tx_word_o,   // tx word
    input wire logic        tx_ready_i,  // tx ready
    input wire logic        dma_valid_o, // dma valid
    input wire logic [31:0] dma_data_o,  // dma data
    input wire logic        dma_ready_i  // dma ready
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // software writes the command byte
    sequence cmd_wr_s;
        wr_i && addr_i == ADDR_STCMD;
    endsequence
    // status read with no frame event close by
    sequence st_rd_s;
        rd_i && addr_i == ADDR_STCMD && !rx_valid_i && !$past(rx_valid_i);
    endsequence
    AST_CMD_FRAME: assert property (cmd_wr_s |-> ##[1:3] tx_valid_o && tx_word_o.sof)
        else $error("no command frame");
    AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_word_o))
        else $error("tx word dropped");
    AST_DMA_HOLD: assert property (dma_valid_o && !dma_ready_i |=> dma_valid_o && $stable(dma_data_o))
        else $error("dma word dropped");
    AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data without strobe");
    AST_RST_READY: assert property ($fell(reset_i) |=> rx_ready_o)
        else $error("link not ready after reset");
    AST_RST_QUIET: assert property ($fell(reset_i) |-> !tx_valid_o && !dma_valid_o && !intrq_o)
        else $error("output active after reset");
    AST_IRQ_CAUSE: assert property ($rose(intrq_o) |-> $past(rx_valid_i) || $past(rx_valid_i, 2))
        else $error("interrupt without frame");
    AST_ST_CLR: assert property (st_rd_s |=> !intrq_o)
        else $error("status read left interrupt");
endmodule
`default_nettype wire

// file: verif/ssrcb_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module ssrcb_dev_model
    import ssrcb_pkg::*;
(
    input  wire logic        clk_i,      // clock
    input  wire logic        ready_i,    // bridge takes word
    input  wire logic        tx_valid_i, // bridge word valid
    input  wire ssrcb_word_t tx_word_i,  // bridge word
    output logic             valid_o,    // word to bridge valid
    output ssrcb_word_t      word_o,     // word to bridge
    output logic             tx_ready_o  // takes bridge word
);
    ssrcb_word_t txq[$];          // words sent by the bridge
    logic [1:0]  n_r = 2'h0;      // stall pacing
    initial valid_o = 1'b0;
    initial word_o = '0;
    initial tx_ready_o = 1'b0;
    // take bridge words, stalling one cycle in four
    always @(posedge clk_i) begin
        n_r <= n_r + 2'h1;
        tx_ready_o <= n_r != 2'h3;
        if (tx_valid_i && tx_ready_o) begin
            txq.push_back(tx_word_i);
        end
    end
    // send one frame, each word held until taken
    task automatic send(input logic [31:0] f[$]);
        for (int i = 0; i < f.size(); i++) begin
            @(posedge clk_i);
            valid_o <= 1'b1;
            word_o <= {i == 0, i == f.size() - 1, f[i]};
            do @(negedge clk_i); while (!ready_i);
        end
        @(posedge clk_i);
        valid_o <= 1'b0;
        word_o <= ~word_o;        // released line shows no stale word
    endtask
endmodule
`default_nettype wire

// file: verif/test_ssrcb_bridge.sv
`timescale 1ns/100ps
`default_nettype none
module test_ssrcb_bridge;
    import ssrcb_pkg::*;
    logic        clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, dma_ready_i = 1'b0;
    logic [5:0]  addr_i = 6'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, dma_data_o, v, dq[$], q[$];
    logic        intrq_o, rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, dma_valid_o;
    ssrcb_word_t rx_word_i, tx_word_o;
    int          n_fail = 0, n_compared = 0;
    ssrcb_bridge dut (.*);
    ssrcb_dev_model dev (.clk_i(clk_i), .ready_i(rx_ready_o), .tx_valid_i(tx_valid_o), .tx_word_i(tx_word_o),
        .valid_o(rx_valid_i), .word_o(rx_word_i), .tx_ready_o(tx_ready_i));
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) if (dma_valid_o && dma_ready_i) dq.push_back(dma_data_o);
    task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        v = rdata_o;
        chk(nm, v, e);
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        rc("state", ADDR_ADPST, 32'h0);
        wr(ADDR_STCMD, 32'h20);
        rc("status", ADDR_STCMD, 32'h80);
        dev.send('{32'h0058605f, 32'h0, 32'h0, 32'hd0000000, 32'h2});
        chk("cmd", dev.txq[0], {2'b10, 32'h00208027});
        rc("held", ADDR_STCMD, 32'h80);
        dev.send('{FIS_DATA, 32'h11111111, 32'h22222222});
        @(negedge clk_i);
        chk("irq", intrq_o, 1'b1);
        rc("status", ADDR_STCMD, 32'h58);
        rc("data", ADDR_DATA, 32'h11111111);
        rc("data", ADDR_DATA, 32'h22222222);
        rc("end", ADDR_STCMD, 32'hd0);
        $display("pio read done");
        dev.txq.delete();
        dev.send('{32'h0058005f, 32'h0, 32'h0, 32'h50000000, 32'h2});
        rc("status", ADDR_STCMD, 32'h58);
        wr(ADDR_DATA, 32'hcafe0001);
        wr(ADDR_DATA, 32'hcafe0002);
        rc("final", ADDR_STCMD, 32'h50);
        repeat (4) @(negedge clk_i);
        chk("tx hdr", dev.txq[0], {2'b10, 32'h46});
        chk("tx last", dev.txq[2], {2'b01, 32'hcafe0002});
        dev.send('{32'h00504034, 32'h0});
        @(negedge clk_i);
        chk("done irq", intrq_o, 1'b1);
        rc("done st", ADDR_STCMD, 32'h50);
        dev.send('{32'h0051405f, 32'h0, 32'h0, 32'h0, 32'h2});
        @(negedge clk_i);
        chk("err irq", intrq_o, 1'b1);
        rc("err st", ADDR_STCMD, 32'h51);
        $display("pio write done");
        wr(ADDR_ADPCTL, 32'h1);
        wr(ADDR_STCMD, 32'hc7);
        dev.send('{32'h00040034, 32'h0});
        rc("release", ADDR_STCMD, 32'h04);
        dev.send('{32'h001000a1, 32'h0});
        @(negedge clk_i);
        chk("service_request_flag irq", intrq_o, 1'b1);
        wr(ADDR_ADPCTL, 32'h0);
        wr(ADDR_STCMD, 32'ha2);
        rc("service_request_flag st", ADDR_ALTCTL, 32'h94);
        dev.send('{32'h00080034, 32'h0, 32'h0, 32'h5, 32'h0});
        rc("tag", ADDR_SECT, 32'h5);
        chk("service_request_flag busy", dev.txq[$-4], {2'b10, 32'h00a28027});
        wr(ADDR_ADPCTL, 32'h1);
        dma_ready_i <= 1'b1;
        dev.send('{FIS_DATA, 32'h0a0a0a0a, 32'h0b0b0b0b});
        repeat (6) @(posedge clk_i);
        chk("dma", {dq[0], dq[1]} == {32'h0a0a0a0a, 32'h0b0b0b0b}, 1'b1);
        $display("queued dma done");
        wr(ADDR_ADPCTL, 32'h0);
        dq.delete();
        q = '{FIS_DATA};
        for (int i = 1; i < 19; i++) begin
            q.push_back(i);
        end
        fork
            dev.send(q);
            begin
                repeat (40) @(negedge clk_i);
                chk("throttle", rx_ready_o, 1'b0);
                rc("backup", ADDR_ADPST, 32'h10);
                wr(ADDR_ADPCTL, 32'h1);
            end
        join
        repeat (30) @(posedge clk_i);
        chk("drained", dq.size(), 18);
        chk("last", dq[17], 32'h12);
        $display("backup done");
        dev.send('{32'h0058205f, 32'h0, 32'h0, 32'h0, 32'h1});
        rc("hold", ADDR_ADPST, 32'h4000);
        reset_i <= 1'b1;
        @(posedge clk_i);
        reset_i <= 1'b0;
        rc("reset", ADDR_ADPST, 32'h0);
        $display("reset done");
        end_of_test();
    end
endmodule
bind ssrcb_bridge ssrcb_props u_props (.*);
`default_nettype wire
